// [verilog/hpd_config.sv]
// hpd_config: port disable masks and max current bytes, per power mode
// assumes cfg writes/reads come from the eeprom loader on clock_i
//
// Functional notes
// - self-powered: ports with a one in the self mask are disabled
// - bus-powered: ports with a one in the bus mask are disabled
// - mask bits 3..1 map ports 3..1; bit 0 reads zero
// - disabled port never offered to the host for enable or enumeration
// - report only the enabled port count and renumber active ports
// - self-powered: report self max current byte, 2 mA per count
// - bus-powered: report bus max current byte, 2 mA per count
`timescale 1ns/1ns
`default_nettype none
module hpd_config (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic self_powered_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   output logic [3:1] port_enabled_o,
   output logic [1:0] port_count_o,
   output logic [1:0] logical_port1_o,
   output logic [1:0] logical_port2_o,
   output logic [1:0] logical_port3_o,
   output logic [7:0] max_current_o
);
   import hpd_pkg::*;

   logic [7:0] port_disable_mask_self_powered_q;
   logic [7:0] port_disable_mask_bus_powered_q;
   logic [7:0] max_current_self_powered_q;
   logic [7:0] max_current_bus_powered_q;
   logic mode_s1_q;
   logic mode_s2_q;
   logic hit_pdm_self;
   logic hit_pdm_bus;
   logic hit_maxc_self;
   logic hit_maxc_bus;
   logic wr_pdm_self;
   logic wr_pdm_bus;
   logic wr_maxc_self;
   logic wr_maxc_bus;
   logic [7:0] wdata_masked;
   logic [7:0] rdata_d;
   logic [3:1] self_ports;
   logic [3:1] bus_ports;
   logic [3:1] dis_sel;
   logic [3:1] en_d;
   logic [1:0] cnt_d;
   logic [1:0] ln1_d;
   logic [1:0] ln2_d;
   logic [1:0] ln3_d;
   logic [7:0] maxc_d;

   // power mode pin is asynchronous to clock_i; sync before use
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_s1_q <= 1'h0;
         mode_s2_q <= 1'h0;
      end else begin
         mode_s1_q <= self_powered_i;
         mode_s2_q <= mode_s1_q;
      end
   end

   // reset leaves the hub bus-powered until the pin has been seen twice
   reset_mode_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !mode_s2_q)
      else $error("mode not bus-powered after reset");
   mode_sync_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(mode_s1_q) |=> mode_s2_q)
      else $error("mode sync stuck");

   // one address port serves both loads and reads
   assign hit_pdm_self = cfg_addr_i == OFS_PDM_SELF;
   assign hit_pdm_bus = cfg_addr_i == OFS_PDM_BUS;
   assign hit_maxc_self = cfg_addr_i == OFS_MAXC_SELF;
   assign hit_maxc_bus = cfg_addr_i == OFS_MAXC_BUS;
   assign wr_pdm_self = cfg_wr_i && hit_pdm_self;
   assign wr_pdm_bus = cfg_wr_i && hit_pdm_bus;
   assign wr_maxc_self = cfg_wr_i && hit_maxc_self;
   assign wr_maxc_bus = cfg_wr_i && hit_maxc_bus;
   // bit 0 is dropped on the way in so it can never read back as one
   assign wdata_masked = cfg_wdata_i & PDM_RD_MASK;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         port_disable_mask_self_powered_q <= RST_PDM_SELF;
      end else if (wr_pdm_self) begin
         port_disable_mask_self_powered_q <= wdata_masked;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         port_disable_mask_bus_powered_q <= RST_PDM_BUS;
      end else if (wr_pdm_bus) begin
         port_disable_mask_bus_powered_q <= wdata_masked;
      end
   end

   // reserved upper bits are kept as written; only bit 0 is forced
   store_self_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_pdm_self |=> port_disable_mask_self_powered_q ==
         {$past(cfg_wdata_i[7:1]), 1'h0})
      else $error("self mask stored wrong");
   store_bus_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_pdm_bus |=> port_disable_mask_bus_powered_q ==
         {$past(cfg_wdata_i[7:1]), 1'h0})
      else $error("bus mask stored wrong");
   reset_mask_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> port_disable_mask_self_powered_q == RST_PDM_SELF
         && port_disable_mask_bus_powered_q == RST_PDM_BUS)
      else $error("mask defaults wrong");

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         max_current_self_powered_q <= RST_MAXC_SELF;
      end else if (wr_maxc_self) begin
         max_current_self_powered_q <= cfg_wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         max_current_bus_powered_q <= RST_MAXC_BUS;
      end else if (wr_maxc_bus) begin
         max_current_bus_powered_q <= cfg_wdata_i;
      end
   end

   maxc_self_wr_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_maxc_self |=> max_current_self_powered_q == $past(cfg_wdata_i))
      else $error("self current byte not loaded");
   maxc_bus_wr_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_maxc_bus |=> max_current_bus_powered_q == $past(cfg_wdata_i))
      else $error("bus current byte not loaded");

   // unmapped offsets read zero
   always_comb begin
      if (hit_pdm_self) begin
         rdata_d = port_disable_mask_self_powered_q;
      end else if (hit_pdm_bus) begin
         rdata_d = port_disable_mask_bus_powered_q;
      end else if (hit_maxc_self) begin
         rdata_d = max_current_self_powered_q;
      end else if (hit_maxc_bus) begin
         rdata_d = max_current_bus_powered_q;
      end else begin
         rdata_d = 8'h00;
      end
   end

   bit0_zero_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (cfg_addr_i == OFS_PDM_SELF || cfg_addr_i == OFS_PDM_BUS)
         |=> cfg_rdata_o[0] == 1'h0)
      else $error("reserved bit 0 reads one");

   // only the pair for the current mode is ever looked at
   assign self_ports = port_disable_mask_self_powered_q[PORT_HI:PORT_LO];
   assign bus_ports = port_disable_mask_bus_powered_q[PORT_HI:PORT_LO];
   assign dis_sel = mode_s2_q ? self_ports : bus_ports;
   assign en_d = ~dis_sel;
   assign cnt_d = 2'(en_d[1]) + 2'(en_d[2]) + 2'(en_d[3]);
   // logical numbers pack active ports from 1 upward; 0 means hidden
   assign ln1_d = en_d[1] ? 2'h1 : 2'h0;
   assign ln2_d = en_d[2] ? 2'(en_d[1]) + 2'h1 : 2'h0;
   assign ln3_d = en_d[3] ? 2'(en_d[1]) + 2'(en_d[2]) + 2'h1 : 2'h0;
   assign maxc_d = mode_s2_q ? max_current_self_powered_q
                             : max_current_bus_powered_q;

   // one cycle of lag buys outputs that all leave a flop
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cfg_rdata_o <= 8'h00;
         port_enabled_o <= 3'h0;
         port_count_o <= 2'h0;
         logical_port1_o <= 2'h0;
         logical_port2_o <= 2'h0;
         logical_port3_o <= 2'h0;
         max_current_o <= 8'h00;
      end else begin
         cfg_rdata_o <= rdata_d;
         port_enabled_o <= en_d;
         port_count_o <= cnt_d;
         logical_port1_o <= ln1_d;
         logical_port2_o <= ln2_d;
         logical_port3_o <= ln3_d;
         max_current_o <= maxc_d;
      end
   end

   self_mask_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      mode_s2_q |=> port_enabled_o ==
         ~$past(port_disable_mask_self_powered_q[3:1]))
      else $error("self mask not applied");
   bus_mask_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !mode_s2_q |=> port_enabled_o ==
         ~$past(port_disable_mask_bus_powered_q[3:1]))
      else $error("bus mask not applied");
   hidden_p1_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !port_enabled_o[1] |-> logical_port1_o == 2'h0)
      else $error("disabled port 1 has a number");
   hidden_port_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !port_enabled_o[2] |-> logical_port2_o == 2'h0)
      else $error("disabled port has a number");
   hidden_p3_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !port_enabled_o[3] |-> logical_port3_o == 2'h0)
      else $error("disabled port 3 has a number");
   port_count_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      port_count_o == 2'(port_enabled_o[1]) + 2'(port_enabled_o[2])
         + 2'(port_enabled_o[3]))
      else $error("port count mismatch");
   first_num_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      port_enabled_o[1] |-> logical_port1_o == 2'h1)
      else $error("port 1 not numbered first");
   mid_num_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      port_enabled_o[2] |-> logical_port2_o != 2'h0
         && logical_port2_o <= port_count_o)
      else $error("port 2 number out of range");
   renumber_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      port_enabled_o[3] |-> logical_port3_o == port_count_o)
      else $error("top port not last number");
   self_cur_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      mode_s2_q |=> max_current_o == $past(max_current_self_powered_q))
      else $error("self current wrong");
   bus_cur_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !mode_s2_q |=> max_current_o == $past(max_current_bus_powered_q))
      else $error("bus current wrong");
endmodule
`default_nettype wire

// [verilog/hpd_pkg.sv]
// hpd_pkg: constants for the hub port disable and power configuration bank
// assumes byte-wide configuration loads addressed by eeprom offset
`default_nettype none
package hpd_pkg;
   localparam logic [7:0] OFS_PDM_SELF = 8'h2a;
   localparam logic [7:0] OFS_PDM_BUS = 8'h2b;
   localparam logic [7:0] OFS_MAXC_SELF = 8'h2c;
   localparam logic [7:0] OFS_MAXC_BUS = 8'h2d;
   localparam logic [7:0] RST_PDM_SELF = 8'h30;
   localparam logic [7:0] RST_PDM_BUS = 8'h30;
   localparam logic [7:0] RST_MAXC_SELF = 8'h01;
   localparam logic [7:0] RST_MAXC_BUS = 8'h00;
   // bit 0 is reserved and reads as zero; bits 3..1 are the port bits
   localparam logic [7:0] PDM_RD_MASK = 8'hfe;
   localparam int PORT_LO = 1;
   localparam int PORT_HI = 3;
   localparam int NUM_PORTS = 3;
endpackage
`default_nettype wire

// [testbench/hpd_host_model.sv]
// hpd_host_model: upstream host view of the hub's reported setup
// assumes it only watches registered outputs of hpd_config
`timescale 1ns/1ns
`default_nettype none
module hpd_host_model (
   input wire logic [1:0] port_count_i,
   input wire logic [7:0] max_current_i,
   output logic [8:0] budget_ma_o,
   output logic [1:0] ports_seen_o
);
   // two milliamperes per count, so the budget is a plain shift
   assign budget_ma_o = {max_current_i, 1'b0};
   assign ports_seen_o = port_count_i;
endmodule
`default_nettype wire

// [testbench/tb_hub_port_disable_power_config.sv]
// tb_hub_port_disable_power_config: self-checking bench for hpd_config
// assumes hpd_pkg and the host model are compiled before it
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,e) begin total_checks++; if ((a) !== (e)) begin failures++; \
$display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_hub_port_disable_power_config;
   import hpd_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, sp = 1'b0, wr = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rd, cur;
   logic [3:1] en;
   logic [1:0] cnt, l1, l2, l3, seen;
   logic [8:0] ma;
   int failures = 0, total_checks = 0;
   hpd_config hpd_config_i(.clock_i(clk), .rst_n_i(rst_n), .self_powered_i(sp),
      .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_rdata_o(rd),
      .port_enabled_o(en), .port_count_o(cnt), .logical_port1_o(l1),
      .logical_port2_o(l2), .logical_port3_o(l3), .max_current_o(cur));
   hpd_host_model hpd_host_model_i(.port_count_i(cnt), .max_current_i(cur),
      .budget_ma_o(ma), .ports_seen_o(seen));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      `CHK(rd, e)
   endtask
   // mode changes pass a two-flop sync plus the output stage
   task automatic set_mode(input logic s);
      sp = s;
      repeat (4) @(negedge clk);
   endtask
   task automatic port_chk(input logic [3:1] dis);
      logic [3:1] e;
      logic [1:0] n;
      e = ~dis;
      n = 2'(e[1]) + 2'(e[2]) + 2'(e[3]);
      `CHK(en, e)
      `CHK(seen, n)
      `CHK(l1, e[1] ? 2'h1 : 2'h0)
      `CHK(l2, e[2] ? 2'(e[1]) + 2'h1 : 2'h0)
      `CHK(l3, e[3] ? n : 2'h0)
   endtask
   task automatic t_reset;
      rd_chk(OFS_PDM_SELF, 8'h30);
      rd_chk(OFS_PDM_BUS, 8'h30);
      rd_chk(OFS_MAXC_SELF, 8'h01);
      rd_chk(OFS_MAXC_BUS, 8'h00);
      port_chk(3'h0);
      `CHK(cur, 8'h00)
      $display("t_reset done");
   endtask
   task automatic t_self;
      set_mode(1'b1);
      `CHK(ma, 9'h002)
      for (int i = 0; i < 8; i++) begin
         // reserved upper bits are written too, bit 0 is forced high
         wr_b(OFS_PDM_SELF, {4'ha, 3'(i), 1'b1});
         port_chk(3'(i));
         rd_chk(OFS_PDM_SELF, {4'ha, 3'(i), 1'b0});
      end
      wr_b(OFS_PDM_SELF, 8'h00);
      wr_b(OFS_PDM_BUS, 8'h04);
      port_chk(3'h0);
      // programmed at the 100 mA ceiling, embedded draw included
      wr_b(OFS_MAXC_SELF, 8'h32);
      `CHK(ma, 9'h064)
      $display("t_self done");
   endtask
   task automatic t_bus;
      wr_b(OFS_MAXC_BUS, 8'h7d);
      `CHK(cur, 8'h32)
      set_mode(1'b0);
      port_chk(3'h2);
      rd_chk(OFS_PDM_BUS, 8'h04);
      `CHK(ma, 9'h0fa)
      wr_b(8'h2e, 8'hff);
      rd_chk(8'h2e, 8'h00);
      port_chk(3'h2);
      $display("t_bus done");
   endtask
   // reset in mid-run with the pin already self-powered: defaults return
   // and the first outputs still show bus-powered values
   task automatic t_midreset;
      wr_b(OFS_MAXC_SELF, 8'h20);
      wr_b(OFS_PDM_BUS, 8'h0e);
      sp = 1'h1;
      rst_n = 1'h0;
      repeat (2) @(negedge clk);
      `CHK(en, 3'h0)
      `CHK(seen, 2'h0)
      rst_n = 1'h1;
      @(negedge clk);
      `CHK(cur, RST_MAXC_BUS)
      port_chk(3'h0);
      repeat (2) @(negedge clk);
      `CHK(cur, RST_MAXC_SELF)
      rd_chk(OFS_PDM_BUS, RST_PDM_BUS);
      $display("t_midreset done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_self();
      t_bus();
      t_midreset();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule
`default_nettype wire
